// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tra_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tra_bus_t bus = '0;
    logic [15:0] cnt_ld = 16'h0000;
    logic [1:0] pin_req = 2'b00;
    logic [1:0] mat_req = 2'b00;
    logic tick_req = 1'b0;
    tra_chin_t ch2_in;
    tra_chin_t ch3_in;
    wire [31:0] rdata;
    wire [1:0] pout;
    wire [1:0] poe;
    wire irq;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int lvl[2];
    int rega[2] = '{0, 0};
    logic [15:0] v;
    bit hit;
    ////////////////////////////////////////////////////////////////////
    tra_far i_far (.cnt_ld(cnt_ld), .pin_req(pin_req), .mat_req(mat_req),
        .tick_req(tick_req), .ch2_in(ch2_in), .ch3_in(ch3_in));
    tra_top i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .ch2_in(ch2_in), .ch3_in(ch3_in), .chan2_pin_a_out(pout[0]),
        .chan2_pin_a_oe(poe[0]), .chan3_pin_a_out(pout[1]),
        .chan3_pin_a_oe(poe[1]), .irq(irq));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    // hang guard, well above the roughly 610 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // each access opens on a fresh edge, so strobes never double up
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus.we <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] exp, string nm);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk);
        bus.re <= 1'b0;
        #1 chk(nm, exp, rdata);
    endtask
    // pin level after one match for a two-bit action code
    function automatic int after_match(int code, int l);
        case (code)
            1: return 0;
            2: return 1;
            3: return 1 - l;
            default: return l;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(90529));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, then a write to the unmapped slot is dropped
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), 0, "reset value");
        end
        wr(4'h7, 32'hFFFF_FFFF);
        rd(4'h7, 0, "unmapped");
        // every compare code, two matches back to back each
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 8; k++) begin
                wr(4'(c), 32'(k));
                lvl[c] = k / 4;
                #1 chk("pin enable", 32'((k % 4) != 0), poe[c]);
                chk("initial level", lvl[c], pout[c]);
                @(posedge clk);
                mat_req[c] <= 1'b1;
                for (int m = 0; m < 2; m++) begin
                    @(posedge clk);
                    mat_req[c] <= (m == 0);
                    lvl[c] = after_match(k % 4, lvl[c]);
                    #1 chk("match level", lvl[c], pout[c]);
                end
            end
        end
        // every capture code: rising pin, falling pin, one channel 4 tick
        for (int c = 0; c < 2; c++) begin
            for (int k = 8; k < 16; k++) begin
                wr(4'(c), 32'(k));
                for (int e = 0; e < 3; e++) begin
                    v = 16'($urandom);
                    @(posedge clk);
                    cnt_ld <= v;
                    if (e < 2)
                        pin_req[c] <= (e == 0);
                    else
                        tick_req <= 1'b1;
                    if (c == 1 && k >= 12)
                        hit = (e == 2);
                    else
                        hit = e < 2 && (k % 4 >= 2 || k % 2 == e);
                    if (hit)
                        rega[c] = v;
                    @(posedge clk);
                    tick_req <= 1'b0;
                    repeat (5) @(posedge clk);
                    rd(4'(2 + c), rega[c], "register a");
                end
            end
        end
        // interrupt raised by a match, masked, then cleared by a one
        wr(4'h4, 32'h0000_000F);
        rd(4'h4, 0, "status cleared");
        wr(4'h5, 32'h0000_0001);
        wr(4'h0, 32'h0000_0001);
        wr(4'h1, 32'h0000_0006);
        @(posedge clk);
        mat_req[0] <= 1'b1;
        @(posedge clk);
        mat_req[0] <= 1'b0;
        rd(4'h4, 1, "status");
        chk("irq raised", 1, irq);
        rd(4'h6, 32'h0000_000E, "pin status");
        wr(4'h5, 0);
        #1 chk("irq masked", 0, irq);
        wr(4'h5, 1);
        wr(4'h4, 1);
        #1 chk("irq cleared", 0, irq);
        rd(4'h4, 0, "status after clear");
        // mid-run reset with the channel 2 pin idling high, then a
        // rising capture set at once: no false edge may follow
        pin_req <= 2'b01;
        repeat (5) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(4'h0, 32'h0000_0008);
        repeat (4) @(posedge clk);
        rd(4'h2, 0, "no capture after reset");
        rd(4'h4, 0, "status after reset");
        rd(4'h0, 8, "control after reset");
        summarize();
    end
endmodule
`default_nettype wire

// file: dv/tra_far.sv
`timescale 1ns/100ps
`default_nettype none
module tra_far (
    input wire logic [15:0] cnt_ld,
    input wire logic [1:0] pin_req,
    input wire logic [1:0] mat_req,
    input wire logic tick_req,
    output var tra_pkg::tra_chin_t ch2_in,
    output var tra_pkg::tra_chin_t ch3_in
);
    import tra_pkg::*;
    logic [1:0] pin_r = 2'b00;
    ////////////////////////////////////////////////////////////////////
    // pins are asynchronous, so they settle mid cycle, never on the edge
    always @(pin_req) begin
        pin_r <= #7 pin_req;
    end
    // counter, matches and channel 4 ticks belong to the timer clock
    always_comb begin
        ch2_in = '{cnt_ld, mat_req[0], pin_r[0], tick_req};
        ch3_in = '{cnt_ld, mat_req[1], pin_r[1], tick_req};
    end
endmodule
`default_nettype wire

// file: inc/tra_pkg.sv
// Summary of operation
// - field bits 3:2 = 00 means compare; code 00 disables pin, else starts low.
// - field bits 3:2 = 01 means compare; code 00 disables pin, else starts high.
// - compare code 01 drives the pin low on every counter match.
// - compare code 10 drives the pin high on every counter match.
// - compare code 11 inverts the pin level on every counter match.
// - capture code 00 stores the counter into register A on rising input edge.
// - capture code 01 stores the counter into register A on falling input edge.
// - capture with bit 1 set captures on both edges; bit 0 ignored.
// - channel 2 capture always uses its own pin; bit 2 ignored.
// - channel 3 capture with bit 2 clear uses its own pin.
// - channel 3 with bits 3:2 = 11 uses channel 4 count clock; bits 1:0 ignored.
// - in that mode capture happens on every channel 4 count up or down.
package tra_pkg;
    localparam int CNT_W = 16;
    // register offsets (word index equals byte address here)
    localparam logic [3:0] OFS_CH2_CTL = 4'h0;
    localparam logic [3:0] OFS_CH3_CTL = 4'h1;
    localparam logic [3:0] OFS_CH2_REGA = 4'h2;
    localparam logic [3:0] OFS_CH3_REGA = 4'h3;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
    localparam logic [3:0] OFS_PIN_STAT = 4'h6;
    // field positions of the 4-bit control field
    localparam int SEL3 = 3;
    localparam int SEL2 = 2;
    // reset values
    localparam logic [3:0] CTL_RST = 4'h0;
    localparam logic [CNT_W-1:0] REGA_RST = 16'h0000;
    localparam logic [3:0] IRQ_RST = 4'h0;
    // interrupt status bits
    localparam int IRQ_CH2_MATCH = 0;
    localparam int IRQ_CH2_CAPT = 1;
    localparam int IRQ_CH3_MATCH = 2;
    localparam int IRQ_CH3_CAPT = 3;

    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] addr;
        logic [31:0] wdata;
    } tra_bus_t;

    // per channel stimulus: counter, compare match, pin input, ch4 ticks
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic match;
        logic pin_in;
        logic alt_tick;
    } tra_chin_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
        logic capt;
        logic matched;
    } tra_chout_t;
endpackage

// file: rtl/tra_chan.sv
`timescale 1ns/100ps
`default_nettype none
module tra_chan #(
    parameter bit HAS_ALT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] ctl,
    input wire logic ctl_wr,
    input wire logic [3:0] ctl_wdata,
    input wire tra_pkg::tra_chin_t chin,
    output tra_pkg::tra_chout_t chout
);
    import tra_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic lvl;
        logic prim;
    } tra_chst_t;

    tra_chst_t st_r, st_nxt;
    logic is_cmp, alt_src, rise, fall, hit;

    ////////////////////////////////////////////////////////////////////////
    // mode decode and edge detection on the synchronised pin
    always_comb begin
        is_cmp = !ctl[SEL3];
        alt_src = HAS_ALT && ctl[SEL3] && ctl[SEL2];
        rise = st_r.prim && st_r.s2 && !st_r.prev;
        fall = st_r.prim && !st_r.s2 && st_r.prev;
        if (alt_src) begin
            hit = chin.alt_tick;
        end else if (ctl[1]) begin
            hit = rise || fall;
        end else if (ctl[0]) begin
            hit = fall;
        end else begin
            hit = rise;
        end
    end

    // prim blocks a false edge right after the synchroniser fills
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = chin.pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.prim = 1'b1;
        // ctl still holds the old field here, so take the written value
        if (ctl_wr && !ctl_wdata[SEL3]) begin
            st_nxt.lvl = ctl_wdata[SEL2];
        end else if (is_cmp && chin.match) begin
            unique case (ctl[1:0])
                2'b01: st_nxt.lvl = 1'b0;
                2'b10: st_nxt.lvl = 1'b1;
                2'b11: st_nxt.lvl = !st_r.lvl;
                2'b00: st_nxt.lvl = st_r.lvl;
            endcase
        end
        // synchroniser keeps sampling in reset: a pin idling high must
        // not look like a rising edge once reset is released
        if (!rst_n) begin
            st_nxt.lvl = 1'b0;
            st_nxt.prim = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    always_comb begin
        chout.pin_out = st_r.lvl && is_cmp;
        chout.pin_oe = is_cmp && (ctl[1:0] != 2'b00);
        chout.capt = !is_cmp && hit;
        chout.matched = is_cmp && chin.match;
    end

    chk_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (is_cmp && ctl[1:0] == 2'b00 && chin.match && !ctl_wr)
        |=> (!chout.pin_oe && chout.pin_out == $past(chout.pin_out)))
        else $error("disabled pin reacted to a match");
    chk_set_low: assert property (@(posedge clk) disable iff (!rst_n)
        (is_cmp && ctl[1:0] == 2'b01 && chin.match && !ctl_wr)
        ##1 (ctl == $past(ctl)) |-> !chout.pin_out)
        else $error("pin not low after match");
    chk_set_high: assert property (@(posedge clk) disable iff (!rst_n)
        (is_cmp && ctl[1:0] == 2'b10 && chin.match && !ctl_wr)
        ##1 (ctl == $past(ctl)) |-> chout.pin_out)
        else $error("pin not high after match");
    chk_toggle_lvl: assert property (@(posedge clk) disable iff (!rst_n)
        (is_cmp && ctl[1:0] == 2'b11 && chin.match && !ctl_wr)
        ##1 (ctl == $past(ctl)) |-> chout.pin_out != $past(chout.pin_out))
        else $error("pin did not toggle");
    chk_rise_capt: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl[SEL3] && !alt_src && ctl[1:0] == 2'b00 && st_r.prim
         && st_r.s2 && !st_r.prev) |-> chout.capt)
        else $error("rising edge missed");
    chk_fall_capt: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl[SEL3] && !alt_src && ctl[1:0] == 2'b01 && st_r.prim
         && !st_r.s2 && st_r.prev) |-> chout.capt)
        else $error("falling edge missed");
endmodule
`default_nettype wire

// file: rtl/tra_top.sv
`timescale 1ns/100ps
`default_nettype none
module tra_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire tra_pkg::tra_bus_t bus,
    output logic [31:0] rdata,
    input wire tra_pkg::tra_chin_t ch2_in,
    input wire tra_pkg::tra_chin_t ch3_in,
    output logic chan2_pin_a_out,
    output logic chan2_pin_a_oe,
    output logic chan3_pin_a_out,
    output logic chan3_pin_a_oe,
    output logic irq
);
    import tra_pkg::*;

    typedef struct packed {
        logic [3:0] chan2_io_ctl;
        logic [3:0] chan3_io_ctl_high;
        logic [CNT_W-1:0] chan2_general_reg_a;
        logic [CNT_W-1:0] chan3_general_reg_a;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [31:0] rdata;
    } tra_st_t;

    tra_st_t st_r, st_nxt;
    tra_chout_t c2, c3;
    logic [3:0] ev;

    ////////////////////////////////////////////////////////////////////////
    // channel 2 ignores bit 2 in capture, so no alternate source
    tra_chan #(.HAS_ALT(1'b0)) u_ch2 (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(st_r.chan2_io_ctl),
        .ctl_wr(bus.we && bus.addr == OFS_CH2_CTL),
        .ctl_wdata(bus.wdata[3:0]),
        .chin(ch2_in),
        .chout(c2)
    );

    // channel 3 may capture on channel 4 counter ticks
    tra_chan #(.HAS_ALT(1'b1)) u_ch3 (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(st_r.chan3_io_ctl_high),
        .ctl_wr(bus.we && bus.addr == OFS_CH3_CTL),
        .ctl_wdata(bus.wdata[3:0]),
        .chin(ch3_in),
        .chout(c3)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file; capture wins over a software write to register A
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        ev[IRQ_CH2_MATCH] = c2.matched;
        ev[IRQ_CH2_CAPT] = c2.capt;
        ev[IRQ_CH3_MATCH] = c3.matched;
        ev[IRQ_CH3_CAPT] = c3.capt;
        st_nxt.rdata = 32'h0000_0000;
        if (bus.we) begin
            unique case (bus.addr)
                OFS_CH2_CTL: st_nxt.chan2_io_ctl = bus.wdata[3:0];
                OFS_CH3_CTL: st_nxt.chan3_io_ctl_high = bus.wdata[3:0];
                OFS_CH2_REGA: st_nxt.chan2_general_reg_a = bus.wdata[15:0];
                OFS_CH3_REGA: st_nxt.chan3_general_reg_a = bus.wdata[15:0];
                OFS_IRQ_STAT: st_nxt.stat = st_r.stat & ~bus.wdata[3:0];
                OFS_IRQ_MASK: st_nxt.mask = bus.wdata[3:0];
                default: ;
            endcase
        end
        if (c2.capt) begin
            st_nxt.chan2_general_reg_a = ch2_in.count;
        end
        if (c3.capt) begin
            st_nxt.chan3_general_reg_a = ch3_in.count;
        end
        // set wins over a clear in the same cycle
        st_nxt.stat = st_nxt.stat | ev;
        if (bus.re) begin
            unique case (bus.addr)
                OFS_CH2_CTL: st_nxt.rdata = {28'h000_0000, st_r.chan2_io_ctl};
                OFS_CH3_CTL: st_nxt.rdata = {28'h000_0000,
                                             st_r.chan3_io_ctl_high};
                OFS_CH2_REGA: st_nxt.rdata = {16'h0000,
                                              st_r.chan2_general_reg_a};
                OFS_CH3_REGA: st_nxt.rdata = {16'h0000,
                                              st_r.chan3_general_reg_a};
                OFS_IRQ_STAT: st_nxt.rdata = {28'h000_0000, st_r.stat};
                OFS_IRQ_MASK: st_nxt.rdata = {28'h000_0000, st_r.mask};
                OFS_PIN_STAT: st_nxt.rdata = {28'h000_0000,
                    c3.pin_oe, c3.pin_out, c2.pin_oe, c2.pin_out};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (!rst_n) begin
            st_nxt.chan2_io_ctl = CTL_RST;
            st_nxt.chan3_io_ctl_high = CTL_RST;
            st_nxt.chan2_general_reg_a = REGA_RST;
            st_nxt.chan3_general_reg_a = REGA_RST;
            st_nxt.stat = IRQ_RST;
            st_nxt.mask = IRQ_RST;
            st_nxt.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; oe low releases the pin to other functions
    always_comb begin
        rdata = st_r.rdata;
        chan2_pin_a_out = c2.pin_out;
        chan2_pin_a_oe = c2.pin_oe;
        chan3_pin_a_out = c3.pin_out;
        chan3_pin_a_oe = c3.pin_oe;
        irq = |(st_r.stat & st_r.mask);
    end

    chk_alt_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.chan3_io_ctl_high[3:2] == 2'b11 && ch3_in.alt_tick && rst_n)
        |=> st_r.chan3_general_reg_a == $past(ch3_in.count))
        else $error("channel 3 alt capture missed");
    chk_ch2_no_alt: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.chan2_io_ctl[3] && ch2_in.alt_tick && !c2.capt)
        |=> st_r.chan2_general_reg_a == $past(st_r.chan2_general_reg_a)
            || $past(bus.we))
        else $error("channel 2 used alternate source");
    chk_init_low: assert property (@(posedge clk) disable iff (!rst_n)
        (bus.we && bus.addr == OFS_CH2_CTL && bus.wdata[3:2] == 2'b00
         && bus.wdata[1:0] != 2'b00) |=> (chan2_pin_a_oe && !chan2_pin_a_out))
        else $error("initial level not low");
    chk_init_high: assert property (@(posedge clk) disable iff (!rst_n)
        (bus.we && bus.addr == OFS_CH2_CTL && bus.wdata[3:2] == 2'b01
         && bus.wdata[1:0] != 2'b00) |=> (chan2_pin_a_oe && chan2_pin_a_out))
        else $error("initial level not high");
    chk_ch3_pin_src: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.chan3_io_ctl_high[3:2] == 2'b10 && c3.capt)
        |=> st_r.chan3_general_reg_a == $past(ch3_in.count))
        else $error("channel 3 pin capture lost");
    chk_event_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (ev != 4'h0) |=> ((st_r.stat & $past(ev)) == $past(ev)))
        else $error("status bit not set by event");

    cov_ch2_toggle: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.chan2_io_ctl == 4'h3 && ch2_in.match);
    cov_ch2_both: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.chan2_io_ctl[3] && st_r.chan2_io_ctl[1] && c2.capt);
    cov_ch3_alt: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.chan3_io_ctl_high[3:2] == 2'b11 && c3.capt);
    cov_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
endmodule
`default_nettype wire
